// file: shared/cecr_pkg.sv
package cecr_pkg;

  // Cluster build
  localparam int          NCORE          = 4;
  localparam logic [9:0]  THREAD_CTX_M1  = 10'h002;  // Three thread contexts per core

  // Address decode: bits 15:13 pick the block, 12:0 the register
  localparam logic [2:0]  BLK_GLOBAL     = 3'h0;
  localparam logic [2:0]  BLK_LOCAL      = 3'h1;    // 0x2000-0x3fff
  localparam logic [2:0]  BLK_OTHER      = 3'h2;    // 0x4000-0x5fff
  localparam logic [12:0] OFF_ERR_CAUSE  = 13'h0048;
  localparam logic [12:0] OFF_COH        = 13'h0008;
  localparam logic [12:0] OFF_CONFIG     = 13'h0010;
  localparam logic [12:0] OFF_OTHER_SEL  = 13'h0018;
  localparam logic [12:0] OFF_BOOT_BASE  = 13'h0020;
  localparam logic [12:0] OFF_IDENT      = 13'h0028;
  localparam logic [12:0] OFF_BOOT_ALT   = 13'h0030;

  // Error cause layout
  localparam int          ERR_TYPE_LSB   = 27;
  localparam int          ERR_TYPE_W     = 5;
  localparam int          ERR_INFO_W     = 27;
  localparam logic [4:0]  ERR_NONE       = 5'h00;
  localparam logic [4:0]  ERR_CFG_WR     = 5'h01;   // Config write via cached address
  localparam logic [4:0]  ERR_CFG_RD     = 5'h02;   // Config read via cached address

  // Invalid-access detail layout (types 1-7)
  localparam int          INV_CCA_LSB    = 15;
  localparam int          INV_REGION_LSB = 12;
  localparam int          INV_CMD_LSB    = 7;
  localparam int          INV_TAG_LSB    = 3;
  localparam logic [2:0]  REGION_MEM     = 3'h0;
  localparam logic [2:0]  REGION_GCR     = 3'h1;
  localparam logic [2:0]  REGION_GIC     = 3'h2;
  localparam logic [2:0]  REGION_MMIO    = 3'h3;
  localparam logic [2:0]  REGION_CPC     = 3'h5;
  localparam logic [4:0]  CMD_LEGACY_WR  = 5'h01;
  localparam logic [4:0]  CMD_LEGACY_RD  = 5'h02;
  localparam logic [4:0]  CMD_COH_RD_OWN = 5'h08;
  localparam logic [4:0]  CMD_COH_WB     = 5'h0d;
  localparam logic [4:0]  CMD_COH_CB     = 5'h10;
  localparam logic [4:0]  CMD_COH_SYNC   = 5'h14;

  // Write-response detail (types 8-15): kind 9:8, addr flag 7
  localparam int          WR_KIND_LSB    = 8;
  localparam logic [1:0]  WR_EXOK        = 2'b01;
  localparam logic [1:0]  WR_SLVERR      = 2'b10;
  localparam logic [1:0]  WR_DECERR      = 2'b11;

  // Intervention detail (types 16-23): core c at 9+3c (resp) and 10+3c (state)
  localparam int          INTV_CORE0_LSB = 9;
  localparam logic [1:0]  COH_INVALID    = 2'h0;
  localparam logic [1:0]  COH_SHARED     = 2'h1;
  localparam logic [1:0]  COH_MODIFIED   = 2'h2;
  localparam logic [1:0]  COH_EXCLUSIVE  = 2'h3;

  // Second-level cache RAM detail (types 24-26)
  localparam int          L2_OP_LSB      = 18;
  localparam int          L2_ARRAY_LSB   = 16;
  localparam logic [1:0]  L2_ARRAY_DATA  = 2'b10;
  localparam logic [4:0]  L2_OP_RD       = 5'h0a;
  localparam logic [4:0]  L2_OP_WR       = 5'h0b;
  localparam logic [4:0]  L2_OP_HIT_WB   = 5'h1b;

  typedef struct packed {
    logic [4:0]                errType;
    logic [26:0]               errInfo;
    logic [NCORE-1:0][7:0]     coh;
    logic [NCORE-1:0][15:0]    otherSel;
    logic [NCORE-1:0][31:0]    bootBase;
    logic [NCORE-1:0][31:0]    bootAlt;
    logic [NCORE-1:0]          cohMode;
    logic                      bootLoaded;
    logic                      respValid;
    logic [31:0]               respData;
  } cecr_state_t;

endpackage

// file: logic/cecr_regs.sv
`timescale 1ns/1ps

module cecr_regs
  import cecr_pkg::*;
(
  input  wire logic                 clock,
  input  wire logic                 arst_n,
  input  wire logic                 reqValid,
  input  wire logic                 reqWrite,
  input  wire logic [15:0]          reqAddr,
  input  wire logic [31:0]          reqWdata,
  input  wire logic [1:0]           reqCore,
  input  wire logic                 reqCached,
  input  wire logic [2:0]           reqCca,
  input  wire logic [3:0]           reqTag,
  input  wire logic [2:0]           reqPort,
  input  wire logic                 errValid,
  input  wire logic [4:0]           errType,
  input  wire logic [26:0]          errInfo,
  input  wire logic [NCORE*32-1:0]  bootBasePins,
  input  wire logic [NCORE*32-1:0]  bootAltPins,
  output logic                      respValid,
  output logic [31:0]               respRdata,
  output logic [31:0]               errCause,
  output logic [NCORE*8-1:0]        cohEnables,
  output logic [NCORE-1:0]          cohMode,
  output logic [NCORE*32-1:0]       bootBase,
  output logic [NCORE*32-1:0]       bootAlt
);

  cecr_state_t s_r;
  cecr_state_t s_nxt;
  logic [2:0]  blk;
  logic [12:0] off;
  logic        remValid;
  logic [1:0]  remTgt;
  logic        accOk;
  logic        intErr;
  logic [26:0] intInfo;
  logic [4:0]  intType;

  // Address split and remote target lookup
  assign blk      = reqAddr[15:13];
  assign off      = reqAddr[12:0];
  assign remValid = (s_r.otherSel[reqCore] < 16'(NCORE));
  assign remTgt   = s_r.otherSel[reqCore][1:0];
  assign accOk    = reqValid && !reqCached;

  // Cached access to the register space is refused and logged
  assign intErr  = reqValid && reqCached;
  assign intType = reqWrite ? ERR_CFG_WR : ERR_CFG_RD;
  always_comb begin
    intInfo = '0;
    intInfo[INV_CCA_LSB +: 3]    = reqCca;
    intInfo[INV_REGION_LSB +: 3] = REGION_GCR;
    intInfo[INV_CMD_LSB +: 5]    = reqWrite ? CMD_LEGACY_WR : CMD_LEGACY_RD;
    intInfo[INV_TAG_LSB +: 4]    = reqTag;
    intInfo[2:0]                 = reqPort;
  end

  // Next-state logic
  always_comb begin
    logic [1:0] tgt;
    logic       tgtOk;
    logic       isCore;
    tgt         = reqCore;
    tgtOk       = 1'b1;
    isCore      = 1'b0;
    s_nxt       = s_r;
    s_nxt.respValid = 1'b0;
    s_nxt.respData  = '0;

    // Boot vectors take the pin values once, the cycle after reset release
    if (!s_r.bootLoaded) begin
      s_nxt.bootLoaded = 1'b1;
      for (int c = 0; c < NCORE; c++) begin
        s_nxt.bootBase[c] = bootBasePins[c*32 +: 32];
        s_nxt.bootAlt[c]  = bootAltPins[c*32 +: 32];
      end
    end

    // Pick the core whose register copy the access reaches
    if (blk == BLK_LOCAL) begin
      isCore = 1'b1;
    end else if (blk == BLK_OTHER) begin
      isCore = 1'b1;
      tgt    = remTgt;
      tgtOk  = remValid;
    end

    if (reqValid) begin
      s_nxt.respValid = 1'b1;
    end

    // Register reads; unmapped or refused addresses return zero
    if (accOk && !reqWrite) begin
      if (blk == BLK_GLOBAL && off == OFF_ERR_CAUSE) begin
        s_nxt.respData = {s_r.errType, s_r.errInfo};
      end else if (isCore && tgtOk) begin
        case (off)
          OFF_COH:       s_nxt.respData = {24'h000000, s_r.coh[tgt]};
          OFF_CONFIG:    s_nxt.respData = {22'h000000, THREAD_CTX_M1};
          OFF_OTHER_SEL: begin
            // Select register exists only in the local block
            if (blk == BLK_LOCAL) begin
              s_nxt.respData = {s_r.otherSel[tgt], 16'h0000};
            end
          end
          OFF_BOOT_BASE: s_nxt.respData = s_r.bootBase[tgt];
          OFF_IDENT:     s_nxt.respData = {30'h00000000, tgt};
          OFF_BOOT_ALT:  s_nxt.respData = s_r.bootAlt[tgt];
          default:       s_nxt.respData = '0;
        endcase
      end
    end

    // Register writes; read-only and unmapped offsets ignore them
    if (accOk && reqWrite) begin
      if (blk == BLK_GLOBAL && off == OFF_ERR_CAUSE) begin
        s_nxt.errType = reqWdata[ERR_TYPE_LSB +: ERR_TYPE_W];
        s_nxt.errInfo = reqWdata[ERR_INFO_W-1:0];
      end else if (isCore && tgtOk) begin
        case (off)
          OFF_COH:       s_nxt.coh[tgt] = reqWdata[7:0];
          OFF_OTHER_SEL: begin
            if (blk == BLK_LOCAL) begin
              s_nxt.otherSel[tgt] = reqWdata[31:16];
            end
          end
          OFF_BOOT_BASE: s_nxt.bootBase[tgt] = reqWdata;
          OFF_BOOT_ALT:  s_nxt.bootAlt[tgt]  = reqWdata;
          default:       s_nxt.bootLoaded    = s_nxt.bootLoaded;
        endcase
      end
    end

    // First error wins; a clearing write in the same cycle lets it in
    if (s_nxt.errType == ERR_NONE) begin
      if (intErr) begin
        s_nxt.errType = intType;
        s_nxt.errInfo = intInfo;
      end else if (errValid && errType != ERR_NONE) begin
        // Detail layouts of types 8-26 arrive packed from the detectors
        s_nxt.errType = errType;
        s_nxt.errInfo = errInfo;
      end
    end

    // Own bit of each enable field drives that core's coherent mode
    for (int c = 0; c < NCORE; c++) begin
      s_nxt.cohMode[c] = s_nxt.coh[c][c];
    end
  end

  // State register; everything resets to zero
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from the state flops
  assign respValid  = s_r.respValid;
  assign respRdata  = s_r.respData;
  assign errCause   = {s_r.errType, s_r.errInfo};
  assign cohEnables = s_r.coh;
  assign cohMode    = s_r.cohMode;
  assign bootBase   = s_r.bootBase;
  assign bootAlt    = s_r.bootAlt;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  // Helper: a write to the error cause register
  logic causeWr;
  assign causeWr = accOk && reqWrite && blk == BLK_GLOBAL && off == OFF_ERR_CAUSE;

  a_type_sticky: assert property (
    s_r.errType != ERR_NONE && !causeWr |=> $stable(s_r.errType) && $stable(s_r.errInfo)
  ) else $error("error type changed while held");

  a_ext_capture: assert property (
    s_r.errType == ERR_NONE && !reqValid && errValid && errType != ERR_NONE
    |=> s_r.errType == $past(errType) && s_r.errInfo == $past(errInfo)
  ) else $error("external error not captured with its detail");

  a_cached_type: assert property (
    s_r.errType == ERR_NONE && reqValid && reqCached
    |=> s_r.errType == ($past(reqWrite) ? ERR_CFG_WR : ERR_CFG_RD)
  ) else $error("cached config access logged with wrong type");

  a_cached_layout: assert property (
    s_r.errType == ERR_NONE && reqValid && reqCached |=>
      s_r.errInfo[INV_REGION_LSB +: 3] == REGION_GCR &&
      s_r.errInfo[INV_CCA_LSB +: 3] == $past(reqCca) &&
      s_r.errInfo[2:0] == $past(reqPort) && s_r.errInfo[26:18] == 9'h000
  ) else $error("cached access detail layout wrong");

  a_remote_write: assert property (
    accOk && reqWrite && blk == BLK_OTHER && off == OFF_COH && remValid
    |=> s_r.coh[$past(remTgt)] == $past(reqWdata[7:0])
  ) else $error("remote enable write missed its target");

  a_ident_read: assert property (
    accOk && !reqWrite && blk == BLK_LOCAL && off == OFF_IDENT
    |=> respValid && respRdata == {30'h00000000, $past(reqCore)}
  ) else $error("ident read wrong core index");

  a_config_read: assert property (
    accOk && !reqWrite && blk == BLK_OTHER && off == OFF_CONFIG && remValid
    |=> respRdata == {22'h000000, THREAD_CTX_M1}
  ) else $error("config read wrong context count");

  a_coh_mode: assert property (
    ##1 cohMode == {s_r.coh[3][3], s_r.coh[2][2], s_r.coh[1][1], s_r.coh[0][0]}
  ) else $error("coherent mode does not follow own enable bit");

  a_other_sel: assert property (
    accOk && !reqWrite && blk == BLK_OTHER && off == OFF_OTHER_SEL
    |=> respRdata == 32'h00000000
  ) else $error("select register visible in remote window");

  a_resp_taken: assert property (
    reqValid |=> respValid
  ) else $error("access not answered one cycle later");

  a_resp_idle: assert property (
    !reqValid |=> !respValid && respRdata == 32'h00000000
  ) else $error("answer without an access");

  a_store_zero: assert property (
    reqValid && reqWrite |=> respRdata == 32'h00000000
  ) else $error("store returned data");

  // Gated on the boot load so the one-time pin capture is not taken for a write
  a_cached_drop: assert property (
    s_r.bootLoaded && reqValid && reqCached |=>
      $stable(s_r.coh) && $stable(s_r.otherSel) && $stable(s_r.bootBase) &&
      $stable(s_r.bootAlt) && respRdata == 32'h00000000
  ) else $error("cached access changed a register or returned data");

  a_remote_guard: assert property (
    s_r.bootLoaded && accOk && reqWrite && blk == BLK_OTHER && !remValid |=>
      $stable(s_r.coh) && $stable(s_r.bootBase) && $stable(s_r.bootAlt)
  ) else $error("remote store landed without a valid target");

  a_sel_write: assert property (
    accOk && reqWrite && blk == BLK_LOCAL && off == OFF_OTHER_SEL
    |=> s_r.otherSel[$past(reqCore)] == $past(reqWdata[31:16])
  ) else $error("select register write lost");

  // Sampled reset in the antecedent keeps the release edge itself out
  a_boot_load: assert property (
    arst_n && !s_r.bootLoaded && !reqValid
    |=> bootBase == $past(bootBasePins) && bootAlt == $past(bootAltPins)
  ) else $error("boot vectors not taken from the pins");

  a_cause_clear: assert property (
    causeWr && reqWdata[ERR_TYPE_LSB +: ERR_TYPE_W] == ERR_NONE && !errValid
    |=> s_r.errType == ERR_NONE
  ) else $error("zero type write did not clear the error");

  // A clear and a new event in one cycle: the event must win
  a_clear_race: assert property (
    causeWr && reqWdata[ERR_TYPE_LSB +: ERR_TYPE_W] == ERR_NONE &&
    errValid && errType != ERR_NONE
    |=> errCause == {$past(errType), $past(errInfo)}
  ) else $error("event lost to a clearing write in the same cycle");

endmodule // cecr_regs

// file: tb/cecr_regs_bench.sv
`timescale 1ns/1ps

module cecr_regs_bench
  import cecr_pkg::*;
;

  logic                 clock, arst_n, reqValid, reqWrite, reqCached, errValid;
  logic [15:0]          reqAddr;
  logic [31:0]          reqWdata, respRdata, errCause, rd;
  logic [1:0]           reqCore;
  logic [2:0]           reqCca, reqPort;
  logic [3:0]           reqTag;
  logic [4:0]           errType;
  logic [26:0]          errInfo, info;
  logic [NCORE*32-1:0]  bootBasePins, bootAltPins, bootBase, bootAlt;
  logic [NCORE*8-1:0]   cohEnables;
  logic [NCORE-1:0]     cohMode;
  logic                 respValid;
  int                   n_fail, comparisons;

  cecr_regs cecr_regs_inst (
    .clock(clock), .arst_n(arst_n), .reqValid(reqValid), .reqWrite(reqWrite),
    .reqAddr(reqAddr), .reqWdata(reqWdata), .reqCore(reqCore), .reqCached(reqCached),
    .reqCca(reqCca), .reqTag(reqTag), .reqPort(reqPort), .errValid(errValid),
    .errType(errType), .errInfo(errInfo), .bootBasePins(bootBasePins),
    .bootAltPins(bootAltPins), .respValid(respValid), .respRdata(respRdata),
    .errCause(errCause), .cohEnables(cohEnables), .cohMode(cohMode),
    .bootBase(bootBase), .bootAlt(bootAlt)
  );

  // 40 MHz clock
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // Compare and count
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One register access; answer is sampled the cycle after it is taken
  task automatic acc(input logic wr, input logic ca, input logic [1:0] core,
                     input logic [15:0] addr, input logic [31:0] wd);
    @(posedge clock);
    reqValid  <= 1'b1;
    reqWrite  <= wr;
    reqCached <= ca;
    reqCore   <= core;
    reqAddr   <= addr;
    reqWdata  <= wd;
    @(posedge clock);
    reqValid  <= 1'b0;
    reqCached <= 1'b0;
    #1;
    chk("respValid", {31'h0, respValid}, 32'h1);
    rd = respRdata;
  endtask

  // One error event pulse
  task automatic err(input logic [4:0] t, input logic [26:0] i);
    @(posedge clock);
    errValid <= 1'b1;
    errType  <= t;
    errInfo  <= i;
    @(posedge clock);
    errValid <= 1'b0;
    #1;
  endtask

  task automatic finish_test();
    if (n_fail == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Whole run needs about a hundred cycles; cut a hang well beyond that
  initial begin
    #(25 * 4000);
    n_fail++;
    finish_test();
  end

  initial begin
    arst_n = 1'b0;
    {reqValid, reqWrite, reqCached, errValid} = 4'h0;
    {reqAddr, reqWdata, reqCore, errType, errInfo} = '0;
    reqCca  = 3'h3;
    reqTag  = 4'h9;
    reqPort = 3'h2;
    for (int c = 0; c < NCORE; c++) begin
      bootBasePins[c*32+:32] = 32'hbf00_0000 + c;
      bootAltPins[c*32+:32]  = 32'h9000_0000 + c;
    end
    repeat (6) @(posedge clock);
    arst_n <= 1'b1;
    @(posedge clock);
    #1;
    chk("errCause", errCause, 32'h0);
    chk("cohEnables", cohEnables, 32'h0);
    for (int c = 0; c < NCORE; c++) begin
      chk("bootBase", bootBase[c*32+:32], 32'hbf00_0000 + c);
      chk("bootAlt", bootAlt[c*32+:32], 32'h9000_0000 + c);
      acc(1'b0, 1'b0, c[1:0], 16'h2028, 32'h0);
      chk("ident", rd, c);
      acc(1'b0, 1'b0, c[1:0], 16'h2010, 32'h0);
      chk("config", rd, {22'h0, THREAD_CTX_M1});
    end
    // Read-only config ignores stores; unmapped reads zero
    acc(1'b1, 1'b0, 2'd0, 16'h2010, 32'hffff_ffff);
    acc(1'b0, 1'b0, 2'd0, 16'h2010, 32'h0);
    chk("config ro", rd, {22'h0, THREAD_CTX_M1});
    acc(1'b0, 1'b0, 2'd0, 16'h2040, 32'h0);
    chk("unmapped", rd, 32'h0);
    acc(1'b0, 1'b0, 2'd0, 16'h2018, 32'h0);
    chk("select reset", rd, 32'h0);
    // Local coherence enables, per-core copy; own bits are only ever set,
    // as nothing here models the cache flush that a clear would need
    acc(1'b1, 1'b0, 2'd1, 16'h2008, 32'h0000_0013);
    chk("cohEnables", cohEnables, 32'h0000_1300);
    chk("cohMode", {28'h0, cohMode}, 32'h2);
    acc(1'b0, 1'b0, 2'd1, 16'h2008, 32'h0);
    chk("coh rd", rd, 32'h13);
    acc(1'b0, 1'b0, 2'd0, 16'h2008, 32'h0);
    chk("coh other copy", rd, 32'h0);
    // Remote window, select written first
    acc(1'b1, 1'b0, 2'd0, 16'h2018, 32'h0002_0000);
    acc(1'b0, 1'b0, 2'd0, 16'h2018, 32'h0);
    chk("select", rd, 32'h0002_0000);
    acc(1'b0, 1'b0, 2'd0, 16'h4028, 32'h0);
    chk("remote ident", rd, 32'h2);
    acc(1'b1, 1'b0, 2'd0, 16'h4008, 32'h0000_0024);
    chk("remote coh", cohEnables, 32'h0024_1300);
    chk("cohMode", {28'h0, cohMode}, 32'h6);
    acc(1'b0, 1'b0, 2'd0, 16'h4018, 32'h0);
    chk("remote select", rd, 32'h0);
    // Select beyond the last core: remote window neither stores nor loads
    acc(1'b1, 1'b0, 2'd0, 16'h2018, 32'h0007_0000);
    acc(1'b1, 1'b0, 2'd0, 16'h4008, 32'h0000_00ff);
    chk("no target", cohEnables, 32'h0024_1300);
    acc(1'b0, 1'b0, 2'd0, 16'h4028, 32'h0);
    chk("no target rd", rd, 32'h0);
    // Boot vectors are programmable per core
    acc(1'b1, 1'b0, 2'd3, 16'h2020, 32'h8000_1000);
    acc(1'b1, 1'b0, 2'd3, 16'h2030, 32'h8000_2000);
    chk("bootBase3", bootBase[127:96], 32'h8000_1000);
    chk("bootAlt3", bootAlt[127:96], 32'h8000_2000);
    chk("bootAlt0", bootAlt[31:0], 32'h9000_0000);
    acc(1'b0, 1'b0, 2'd3, 16'h2020, 32'h0);
    chk("bootBase3 rd", rd, 32'h8000_1000);
    // Write response error, then a later one is dropped
    info = {17'h0, WR_SLVERR, 1'b1, 4'h5, 3'h3};
    err(5'd9, info);
    chk("errCause wr", errCause, {5'd9, info});
    err(5'd17, 27'h7ff_ffff);
    chk("errCause held", errCause, {5'd9, info});
    acc(1'b1, 1'b0, 2'd0, 16'h0048, 32'h0);
    chk("errCause clr", errCause, 32'h0);
    // Intervention error
    info = {6'h0, COH_EXCLUSIVE, 1'b1, COH_MODIFIED, 1'b0, COH_SHARED, 1'b1,
            COH_INVALID, 1'b0, 1'b1, CMD_COH_SYNC, 3'h4};
    err(5'd17, info);
    chk("errCause intv", errCause, {5'd17, info});
    acc(1'b1, 1'b0, 2'd0, 16'h0048, 32'h0);
    // Cache RAM error
    info = {3'h0, 1'b1, L2_OP_HIT_WB, L2_ARRAY_DATA, 4'h7, 3'h5, 1'b0, 8'ha5};
    err(5'd24, info);
    chk("errCause l2", errCause, {5'd24, info});
    acc(1'b1, 1'b0, 2'd0, 16'h0048, 32'h0);
    // Cached load is refused and logged
    acc(1'b0, 1'b1, 2'd1, 16'h2028, 32'h0);
    chk("cached rd", rd, 32'h0);
    chk("errCause crd", errCause, {ERR_CFG_RD, 9'h0, 3'h3, REGION_GCR,
        CMD_LEGACY_RD, 4'h9, 3'h2});
    acc(1'b1, 1'b0, 2'd0, 16'h0048, 32'h0);
    // Cached store is dropped and logged
    acc(1'b1, 1'b1, 2'd1, 16'h2008, 32'h0000_00ff);
    chk("cached wr", cohEnables, 32'h0024_1300);
    chk("errCause cwr", errCause, {ERR_CFG_WR, 9'h0, 3'h3, REGION_GCR,
        CMD_LEGACY_WR, 4'h9, 3'h2});
    // Clearing write and a new event in one cycle: the event wins
    info = {17'h0, WR_DECERR, 1'b0, 4'h1, 3'h6};
    fork
      acc(1'b1, 1'b0, 2'd0, 16'h0048, 32'h0);
      err(5'd8, info);
    join
    chk("errCause race", errCause, {5'd8, info});
    acc(1'b1, 1'b0, 2'd0, 16'h0048, 32'h0);
    // Cached access and an event in one cycle: the access is logged
    fork
      acc(1'b0, 1'b1, 2'd2, 16'h2010, 32'h0);
      err(5'd26, 27'h123_4567);
    join
    chk("errCause both", {27'h0, errCause[31:27]}, {27'h0, ERR_CFG_RD});
    // Power-on reset mid-run drops the held error and the select, reloads pins
    @(posedge clock);
    arst_n <= 1'b0;
    repeat (2) @(posedge clock);
    arst_n <= 1'b1;
    @(posedge clock);
    #1;
    chk("errCause por", errCause, 32'h0);
    chk("bootBase por", bootBase[127:96], 32'hbf00_0003);
    acc(1'b0, 1'b0, 2'd0, 16'h2018, 32'h0);
    chk("select por", rd, 32'h0);
    finish_test();
  end

endmodule // cecr_regs_bench
